/* File: hw/drc_pkg.sv */
// Package: register map, field layout and codes of the tx irq / rx control bank
package drc_pkg;

  // Register offsets on the control port
  localparam logic [7:0] DRC_ADDR_TX_STATUS = 8'h0A;
  localparam logic [7:0] DRC_ADDR_TX_MASK   = 8'h0B;
  localparam logic [7:0] DRC_ADDR_TX_TRIG   = 8'h0C;
  localparam logic [7:0] DRC_ADDR_RX_CTRL1  = 8'h0D;
  localparam logic [7:0] DRC_ADDR_RX_CTRL2  = 8'h0E;
  localparam logic [7:0] DRC_ADDR_PLL_CFG1  = 8'h0F;

  // Reset values
  localparam logic [7:0] DRC_RST_TX_MASK  = 8'h00;
  localparam logic [7:0] DRC_RST_TX_TRIG  = 8'h00;
  localparam logic [7:0] DRC_RST_RX_CTRL1 = 8'h00;
  localparam logic [7:0] DRC_RST_RX_CTRL2 = 8'h00;
  localparam logic [7:0] DRC_RST_PLL_CFG1 = 8'h00;

  // Writable bits; all others are reserved and read as zero
  localparam logic [7:0] DRC_WMASK_TX_MASK  = 8'h03;
  localparam logic [7:0] DRC_WMASK_TX_TRIG  = 8'h0F;
  localparam logic [7:0] DRC_WMASK_RX_CTRL1 = 8'h1B;
  localparam logic [7:0] DRC_WMASK_RX_CTRL2 = 8'h1F;
  localparam logic [7:0] DRC_WMASK_PLL_CFG1 = 8'hFF;

  // Event index: status, mask and trigger fields share it
  localparam int DRC_EV_BUF_DONE = 0;
  localparam int DRC_EV_SLIP     = 1;
  localparam int DRC_NUM_EV      = 2;
  localparam int DRC_TRIG_W      = 2;

  // Receiver control 1 fields
  localparam int DRC_RXC1_INPUT_LSB = 0;
  localparam int DRC_RXC1_REF_BIT   = 3;
  localparam int DRC_RXC1_BTD_BIT   = 4;

  // Receiver control 2 fields
  localparam int DRC_RXC2_OE_BIT    = 0;
  localparam int DRC_RXC2_DIV_LSB   = 1;
  localparam int DRC_RXC2_MUTE_BIT  = 3;
  localparam int DRC_RXC2_FREE_BIT  = 4;

  // Decoder pll config 1 fields
  localparam int DRC_PLL_PREDIV_LSB = 4;
  localparam int DRC_PLL_MULTHI_LSB = 0;

  // Trigger mode codes
  localparam logic [1:0] DRC_TRIG_RISE  = 2'h0;
  localparam logic [1:0] DRC_TRIG_FALL  = 2'h1;
  localparam logic [1:0] DRC_TRIG_LEVEL = 2'h2;

  // Depth of the pin synchroniser
  localparam int DRC_SYNC_DEPTH = 3;

endpackage : drc_pkg

/* File: hw/drc_event_trigger.sv */
// Edge / level trigger detector for one internal event condition
`timescale 1ns/10ps
module drc_event_trigger (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       cond,
  input  wire logic [1:0] mode,
  output logic            hit
);

  logic cond_q;  // Condition one enabled cycle ago

  // Previous condition, frozen with the clock enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cond_q <= 1'b0;
    end else if (ce) begin
      cond_q <= cond;
    end
  end

  // One hit per transition in edge modes, every cycle the condition is high in level mode
  always_comb begin
    case (mode)
      drc_pkg::DRC_TRIG_RISE:  hit = cond & ~cond_q;
      drc_pkg::DRC_TRIG_FALL:  hit = ~cond & cond_q;
      drc_pkg::DRC_TRIG_LEVEL: hit = cond;
      // Reserved code never triggers
      default:                 hit = 1'b0;
    endcase
  end

endmodule : drc_event_trigger

/* File: hw/drc_ctrl_regs.sv */
// Top: transmitter interrupt flags and receiver control register bank
`timescale 1ns/10ps
module drc_ctrl_regs (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  input  wire logic       tx_buffer_transfer_disable,
  input  wire logic       slip_source_select,
  input  wire logic       tx_transfer_done,
  input  wire logic       tx_async_slip,
  input  wire logic       tx_block_start,
  output logic            int_n,
  output logic            tx_summary,
  output logic      [1:0] receiver_input_select,
  output logic            receiver_reference_select,
  output logic            receiver_buffer_transfer_disable,
  output logic      [3:0] decoder_pll_prediv,
  output logic      [3:0] decoder_pll_mult_hi,
  input  wire logic       decoder_unlock,
  input  wire logic       recovery_pll_unlock,
  input  wire logic       recovery_pll_tick,
  input  wire logic       rx_audio_in,
  output logic            rx_audio_out,
  output logic            recovered_clock_out,
  output logic            recovered_clock_out_oe
);

  // Register storage
  logic [7:0] tx_mask;      // Interrupt mask
  logic [7:0] tx_trig;      // Trigger modes
  logic [7:0] rx_ctrl1;     // Receiver control 1
  logic [7:0] rx_ctrl2;     // Receiver control 2
  logic [7:0] pll_cfg1;     // Decoder pll config 1

  // Event path
  logic [1:0] ev_cond;      // Raw conditions per event
  logic [1:0] ev_hit;       // Detected triggers per event
  logic [1:0] ev_set;       // Qualified flag sets
  logic [1:0] flags;        // Sticky status flags
  logic [1:0] next_flags;   // Flags after this cycle
  logic       status_clr;   // Status read clears flags

  // Unlock synchronisers and filtered levels
  logic [2:0] dec_sync;     // Decoder unlock sync chain
  logic [2:0] pll_sync;     // Pll unlock sync chain
  logic       dec_lost;     // Filtered decoder unlock
  logic       pll_lost;     // Filtered recovery pll unlock

  // Recovered clock divider
  logic [2:0] div_cnt;      // Ticks since last toggle
  logic [3:0] div_span;     // Ticks per half period
  logic [2:0] div_limit;    // Last count before toggle
  logic       clk_run;      // Divider allowed to run

  // Field decodes
  logic [1:0] div_code;     // Divider select code
  logic       mute_en;      // Auto-mute enable
  logic       free_run;     // Free-run on unlock

  assign div_code = rx_ctrl2[drc_pkg::DRC_RXC2_DIV_LSB +: 2];
  assign mute_en  = rx_ctrl2[drc_pkg::DRC_RXC2_MUTE_BIT];
  assign free_run = rx_ctrl2[drc_pkg::DRC_RXC2_FREE_BIT];

  // Host register writes; reserved bits never store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_mask  <= drc_pkg::DRC_RST_TX_MASK;
      tx_trig  <= drc_pkg::DRC_RST_TX_TRIG;
      rx_ctrl1 <= drc_pkg::DRC_RST_RX_CTRL1;
      rx_ctrl2 <= drc_pkg::DRC_RST_RX_CTRL2;
      pll_cfg1 <= drc_pkg::DRC_RST_PLL_CFG1;
    end else if (ce && reg_wr) begin
      case (reg_addr)
        drc_pkg::DRC_ADDR_TX_MASK: begin
          tx_mask <= reg_wdata & drc_pkg::DRC_WMASK_TX_MASK;
        end
        drc_pkg::DRC_ADDR_TX_TRIG: begin
          tx_trig <= reg_wdata & drc_pkg::DRC_WMASK_TX_TRIG;
        end
        drc_pkg::DRC_ADDR_RX_CTRL1: begin
          rx_ctrl1 <= reg_wdata & drc_pkg::DRC_WMASK_RX_CTRL1;
        end
        drc_pkg::DRC_ADDR_RX_CTRL2: begin
          rx_ctrl2 <= reg_wdata & drc_pkg::DRC_WMASK_RX_CTRL2;
        end
        drc_pkg::DRC_ADDR_PLL_CFG1: begin
          pll_cfg1 <= reg_wdata & drc_pkg::DRC_WMASK_PLL_CFG1;
        end
        // Status is read-only; unmapped writes vanish
        default: begin
        end
      endcase
    end
  end

  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          drc_pkg::DRC_ADDR_TX_STATUS: reg_rdata <= {6'h00, flags};
          drc_pkg::DRC_ADDR_TX_MASK:   reg_rdata <= tx_mask;
          drc_pkg::DRC_ADDR_TX_TRIG:   reg_rdata <= tx_trig;
          drc_pkg::DRC_ADDR_RX_CTRL1:  reg_rdata <= rx_ctrl1;
          drc_pkg::DRC_ADDR_RX_CTRL2:  reg_rdata <= rx_ctrl2;
          drc_pkg::DRC_ADDR_PLL_CFG1:  reg_rdata <= pll_cfg1;
          // Unmapped offsets answer zero
          default:                     reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Event conditions; slip source chosen by the select input
  assign ev_cond[drc_pkg::DRC_EV_BUF_DONE] = tx_transfer_done;
  assign ev_cond[drc_pkg::DRC_EV_SLIP] =
    slip_source_select ? tx_block_start : tx_async_slip;

  // One trigger detector per event, mode from its own field
  generate
    for (genvar g = 0; g < drc_pkg::DRC_NUM_EV; g++) begin : g_trig
      drc_event_trigger u_trig (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .cond    (ev_cond[g]),
        .mode    (tx_trig[g*drc_pkg::DRC_TRIG_W +: drc_pkg::DRC_TRIG_W]),
        .hit     (ev_hit[g])
      );
    end
  endgenerate

  // Qualify triggers with masks; transfer disable suppresses buffer done
  assign ev_set[drc_pkg::DRC_EV_BUF_DONE] =
    ev_hit[drc_pkg::DRC_EV_BUF_DONE]
    & ~tx_buffer_transfer_disable
    & tx_mask[drc_pkg::DRC_EV_BUF_DONE];
  assign ev_set[drc_pkg::DRC_EV_SLIP] =
    ev_hit[drc_pkg::DRC_EV_SLIP]
    & tx_mask[drc_pkg::DRC_EV_SLIP];

  // Reading status clears it; a set in the same cycle wins
  assign status_clr = reg_rd && (reg_addr == drc_pkg::DRC_ADDR_TX_STATUS);
  assign next_flags = ev_set | (flags & ~{2{status_clr}});

  // Sticky flags and the derived interrupt outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags      <= 2'h0;
      int_n      <= 1'b1;
      tx_summary <= 1'b0;
    end else if (ce) begin
      flags      <= next_flags;
      int_n      <= ~(|next_flags);
      tx_summary <= |next_flags;
    end
  end

  // Receiver control fields out as plain flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      receiver_input_select            <= 2'h0;
      receiver_reference_select        <= 1'b0;
      receiver_buffer_transfer_disable <= 1'b0;
      decoder_pll_prediv               <= 4'h0;
      decoder_pll_mult_hi              <= 4'h0;
      recovered_clock_out_oe           <= 1'b0;
    end else if (ce) begin
      receiver_input_select <=
        rx_ctrl1[drc_pkg::DRC_RXC1_INPUT_LSB +: 2];
      receiver_reference_select <=
        rx_ctrl1[drc_pkg::DRC_RXC1_REF_BIT];
      receiver_buffer_transfer_disable <=
        rx_ctrl1[drc_pkg::DRC_RXC1_BTD_BIT];
      // Pll fields pass through raw; legal ranges are the host's job
      decoder_pll_prediv <=
        pll_cfg1[drc_pkg::DRC_PLL_PREDIV_LSB +: 4];
      decoder_pll_mult_hi <=
        pll_cfg1[drc_pkg::DRC_PLL_MULTHI_LSB +: 4];
      recovered_clock_out_oe <=
        rx_ctrl2[drc_pkg::DRC_RXC2_OE_BIT];
    end
  end

  // Lock indications come from analog domains: three-flop chain
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_sync <= 3'h0;
      pll_sync <= 3'h0;
    end else if (ce) begin
      dec_sync <= {dec_sync[1:0], decoder_unlock};
      pll_sync <= {pll_sync[1:0], recovery_pll_unlock};
    end
  end

  // Accept a new level only when stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dec_lost <= 1'b0;
      pll_lost <= 1'b0;
    end else if (ce) begin
      if (dec_sync[1] == dec_sync[2]) begin
        dec_lost <= dec_sync[2];
      end
      if (pll_sync[1] == pll_sync[2]) begin
        pll_lost <= pll_sync[2];
      end
    end
  end

  // Auto-mute needs both decoder and pll to report unlock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_audio_out <= 1'b0;
    end else if (ce) begin
      if (mute_en && dec_lost && pll_lost) begin
        rx_audio_out <= 1'b0;
      end else begin
        rx_audio_out <= rx_audio_in;
      end
    end
  end

  // Divider: each pll tick is a half period of the undivided clock
  assign div_span  = 4'h1 << div_code;
  assign div_limit = 3'(div_span - 4'h1);
  assign clk_run   = ~pll_lost | free_run;

  // Recovered clock; stopped low at once on pll unlock unless free-run is set, so a high phase in progress is cut short
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt             <= 3'h0;
      recovered_clock_out <= 1'b0;
    end else if (ce) begin
      if (!clk_run) begin
        div_cnt             <= 3'h0;
        recovered_clock_out <= 1'b0;
      end else if (recovery_pll_tick) begin
        if (div_cnt >= div_limit) begin
          div_cnt             <= 3'h0;
          recovered_clock_out <= ~recovered_clock_out;
        end else begin
          div_cnt <= div_cnt + 3'h1;
        end
      end
    end
  end

  // Checks next to the logic they guard
  a_buf_done_set: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ev_hit[0] && !tx_buffer_transfer_disable && tx_mask[0]
      |=> flags[0])
    else $error("buffer done event lost");
  a_buf_done_block: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && !flags[0] && (tx_buffer_transfer_disable || !tx_mask[0])
      |=> !flags[0])
    else $error("buffer done set while disabled or masked");
  a_int_on_done: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ev_set[0] |=> !int_n && tx_summary)
    else $error("interrupt not raised for buffer done");
  a_slip_set: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ev_hit[1] && tx_mask[1] |=> flags[1] && !int_n)
    else $error("slip event lost");
  a_slip_source: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && tx_mask[1] && tx_trig[3:2] == drc_pkg::DRC_TRIG_LEVEL
      && slip_source_select && tx_block_start |=> flags[1])
    else $error("block start did not set slip");
  a_int_matches: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    int_n == !(|flags) && tx_summary == (|flags))
    else $error("interrupt outputs disagree with flags");
  a_rise_once: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && tx_trig[1:0] == drc_pkg::DRC_TRIG_RISE && ev_hit[0]
      ##1 ce && tx_trig[1:0] == drc_pkg::DRC_TRIG_RISE |-> !ev_hit[0])
    else $error("rising trigger fired twice");
  a_status_zero: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && reg_rd && reg_addr == drc_pkg::DRC_ADDR_TX_STATUS
      |=> reg_rvalid && reg_rdata[7:2] == 6'h00
          && reg_rdata[1:0] == $past(flags))
    else $error("status read answer wrong");
  a_oe_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce |=> recovered_clock_out_oe == $past(rx_ctrl2[0]))
    else $error("recovered clock enable wrong");
  a_mute_data: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && mute_en && dec_lost && pll_lost |=> !rx_audio_out)
    else $error("audio not muted on unlock");
  a_clock_stop: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && pll_lost && !free_run
      |=> !recovered_clock_out && div_cnt == 3'h0)
    else $error("recovered clock ran while unlocked");

  c_buf_done_irq: cover property (
    @(posedge clk_sys) disable iff (!rst_n) ce && ev_set[0] ##1 !int_n);
  c_slip_block: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && ev_set[1] && slip_source_select);
  c_set_on_clear: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    ce && status_clr && |ev_set);
  c_div_eight: cover property (
    @(posedge clk_sys) disable iff (!rst_n)
    div_code == 2'h3 && recovered_clock_out);

endmodule : drc_ctrl_regs

/* File: sim/drc_host_model.sv */
// Host model: drives register strobes of the control port
`timescale 1ns/10ps
module drc_host_model (
  input  wire logic       clk_sys,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  // Idle bus from time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  // One write; strobe held for exactly one taken edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // Stale address would hide a decoder that ignores the strobe
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr

  // One read; answer registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [8:0] r);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    r = {reg_rvalid, reg_rdata};
  endtask : rd
endmodule : drc_host_model

/* File: sim/drc_ctrl_regs_tb.sv */
// Self-checking bench for the tx irq and rx control register bank
`timescale 1ns/10ps
module drc_ctrl_regs_tb;
  // Design pins, named as the ports
  logic       clk_sys, rst_n, ce, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       tx_buffer_transfer_disable, slip_source_select;
  logic       tx_transfer_done, tx_async_slip, tx_block_start;
  logic       int_n, tx_summary, receiver_reference_select;
  logic       receiver_buffer_transfer_disable, rx_audio_in;
  logic       rx_audio_out, decoder_unlock, recovery_pll_unlock;
  logic       recovery_pll_tick, recovered_clock_out;
  logic       recovered_clock_out_oe;
  logic [1:0] receiver_input_select;
  logic [3:0] decoder_pll_prediv, decoder_pll_mult_hi;
  int         fails, total_checks;   // Mismatches and comparisons
  // Register offsets, last one unmapped, and writable bits
  logic [7:0] adr [7] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F,
                          8'h10};
  logic [7:0] wmk [7] = '{8'h00, 8'h03, 8'h0F, 8'h1B, 8'h1F, 8'hFF,
                          8'h00};

  drc_ctrl_regs uut (
    .clk_sys, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .reg_rvalid, .tx_buffer_transfer_disable,
    .slip_source_select, .tx_transfer_done, .tx_async_slip,
    .tx_block_start, .int_n, .tx_summary, .receiver_input_select,
    .receiver_reference_select, .receiver_buffer_transfer_disable,
    .decoder_pll_prediv, .decoder_pll_mult_hi, .decoder_unlock,
    .recovery_pll_unlock, .recovery_pll_tick, .rx_audio_in,
    .rx_audio_out, .recovered_clock_out, .recovered_clock_out_oe
  );

  drc_host_model host (
    .clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid
  );

  // 100 ns clock
  always #50 clk_sys = ~clk_sys;

  // Compare and count; a mismatch is reported at once
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // End-of-test line
  task automatic test_end(input string s);
    $display("test %s ends, checks=%0d", s, total_checks);
  endtask : test_end

  // Counts and verdict, then stop
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Drive one event source; alt picks the unselected slip source
  task automatic drive(input logic ev, input logic alt, input logic v);
    @(posedge clk_sys);
    if (!ev) tx_transfer_done <= v;
    else if (slip_source_select ^ alt) tx_block_start <= v;
    else tx_async_slip <= v;
  endtask : drive

  // One event case: rise then fall of the condition, then status
  task automatic ev_case(input logic [4:0] i);
    logic [8:0] r;
    logic [1:0] m;
    logic       ev, alt, en, f1, f2;
    ev  = i[0];
    m   = i[2:1];
    alt = i[3];
    en  = ~i[4] | 1'($urandom_range(0, 1));
    host.wr(8'h0C, 8'(m) << (2 * ev));
    host.wr(8'h0B, 8'(en) << ev);
    @(posedge clk_sys);
    // Disable only matters to buffer-done; random on the slip side
    tx_buffer_transfer_disable <= ev ? 1'($urandom_range(0, 1)) : alt;
    // Slip side walks both sources per trigger code; buffer side random
    slip_source_select         <= ev ? ~i[4] : 1'($urandom_range(0, 1));
    repeat (2) @(posedge clk_sys);
    f1 = en & ~alt & ~m[0];
    f2 = en & ~alt & (m != 2'h3);
    drive(ev, alt, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(9'({int_n, tx_summary}), 9'({~f1, f1}));
    drive(ev, alt, 1'b0);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(9'({int_n, tx_summary}), 9'({~f2, f2}));
    host.rd(8'h0A, r);
    chk(r, {1'b1, 8'(f2) << ev});
    host.rd(8'h0A, r);
    chk({r[8:0]}, 9'h100);
  endtask : ev_case

  // Transitions of the recovered clock over n cycles
  task automatic count_tog(input int n, output int t);
    logic p;
    t = 0;
    @(posedge clk_sys);
    #1;
    p = recovered_clock_out;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      if (recovered_clock_out !== p) t++;
      p = recovered_clock_out;
    end
  endtask : count_tog

  // Watchdog: ample margin over the roughly 1300 cycles needed
  initial begin
    #(100 * 20000);
    fails++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    logic [8:0] r;
    logic [7:0] lastw [7];
    logic [1:0] cd;
    int         t, e;
    {clk_sys, rst_n, tx_buffer_transfer_disable, slip_source_select,
     tx_transfer_done, tx_async_slip, tx_block_start, decoder_unlock,
     recovery_pll_unlock, recovery_pll_tick, rx_audio_in} = '0;
    ce = 1'b1;
    void'($urandom(32'h25BE729A));
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // Reset values, unmapped place included
    for (int i = 0; i < 7; i++) begin
      host.rd(adr[i], r);
      chk(r, 9'h100);
    end
    chk(9'({int_n, tx_summary, recovered_clock_out_oe}), 9'h4);
    test_end("reset");
    // Random writes, read back through the writable masks
    repeat (3) for (int i = 0; i < 7; i++) begin
      lastw[i] = 8'($urandom);
      host.wr(adr[i], lastw[i]);
      host.rd(adr[i], r);
      chk(r, {1'b1, lastw[i] & wmk[i]});
    end
    repeat (2) @(posedge clk_sys);
    #1;
    chk(9'({receiver_buffer_transfer_disable, receiver_reference_select,
            1'b0, receiver_input_select}), 9'(lastw[3] & 8'h1B));
    chk(9'({decoder_pll_prediv, decoder_pll_mult_hi}), 9'(lastw[5]));
    chk(9'(recovered_clock_out_oe), 9'(lastw[4][0]));
    // Write with the clock enable low is dropped
    @(posedge clk_sys) ce <= 1'b0;
    host.wr(adr[1], ~lastw[1]);
    @(posedge clk_sys) ce <= 1'b1;
    host.rd(adr[1], r);
    chk(r, {1'b1, lastw[1] & wmk[1]});
    test_end("registers");
    // Both events, every trigger code, masks and suppressions
    for (int i = 0; i < 32; i++) ev_case(5'(i));
    test_end("events");
    // Auto-mute only with the bit set and both sides unlocked
    for (int k = 0; k < 4; k++) begin
      host.wr(8'h0E, (k == 3) ? 8'h00 : 8'h08);
      @(posedge clk_sys);
      decoder_unlock      <= (k != 2);
      recovery_pll_unlock <= (k != 1);
      // Muted case drives a one so a missing mute shows
      rx_audio_in         <= (k == 0) | 1'($urandom_range(0, 1));
      repeat (10) @(posedge clk_sys);
      #1;
      chk(9'(rx_audio_out), 9'(rx_audio_in & (k != 0)));
    end
    test_end("mute");
    // Divider codes, then unlock with stop and with free-run
    @(posedge clk_sys);
    decoder_unlock    <= 1'b0;
    recovery_pll_tick <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      cd = (c < 4) ? 2'(c) : 2'h0;
      e  = (c == 4) ? 0 : (64 >> cd);
      host.wr(8'h0E, 8'({c == 5, 1'b0, cd, c[0]}));
      @(posedge clk_sys) recovery_pll_unlock <= (c >= 4);
      repeat (10) @(posedge clk_sys);
      count_tog(64, t);
      chk(9'((e == 0) ? (t == 0 && !recovered_clock_out) :
             (t >= e - 1 && t <= e + 1)), 9'h1);
      chk(9'(recovered_clock_out_oe), 9'(c[0]));
    end
    test_end("clock");
    report_and_stop();
  end
endmodule : drc_ctrl_regs_tb
